/* File: verilog/ebc_consts.vh */
`ifndef EBC_CONSTS_VH
`define EBC_CONSTS_VH
`define EBC_HIST_DEPTH 8192
`define EBC_HIST_AW 13
`define EBC_HIST_W 88
`define EBC_ADDR_W 12
`define EBC_RADDR_W 12
`define EBC_DATA_W 4
`define EBC_REG_W 32
`define EBC_TRACE_PAUSE 4'h8
`define EBC_CAUSE_NONE 2'h0
`define EBC_CAUSE_MATCH 2'h1
`define EBC_CAUSE_ESC 2'h2
`define EBC_CAUSE_SW 2'h3
`define EBC_RST_BREAK_EN 1'b1
`define EBC_RST_TRACE 1'b0
`endif

/* File: verilog/ebc_hist_mem.v */
`timescale 1ns/1ps
`include "ebc_consts.vh"
module ebc_hist_mem (
  input wire i_clk, // System clock
  input wire i_we, // Write strobe
  input wire [`EBC_HIST_AW-1:0] i_waddr, // Write address
  input wire [`EBC_HIST_W-1:0] i_wdata, // Write data
  input wire [`EBC_HIST_AW-1:0] i_raddr, // Read address
  output reg [`EBC_HIST_W-1:0] o_rdata // Registered read data
);
  reg [`EBC_HIST_W-1:0] mem [0:`EBC_HIST_DEPTH-1];
  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule // ebc_hist_mem

/* File: verilog/ebc_break_ctrl.v */
`timescale 1ns/1ps
`include "ebc_consts.vh"
module ebc_break_ctrl (
  input wire i_clk, // System clock
  input wire i_sys_rst, // Sync reset, high
  input wire i_run_cmd, // Run command pulse
  input wire i_step_cmd, // Single-step command pulse
  input wire i_enable_break_command, // Select break enable
  input wire i_disable_break_command, // Select break disable
  input wire i_trace_break_command, // Select break trace
  input wire i_stop_break_command, // Select break stop
  input wire i_pulse_out_command, // Sync output enable value
  input wire i_pulse_out_write, // Load sync output enable
  input wire i_host_escape_request, // Host escape pulse
  input wire i_break_sw, // Break switch pulse
  input wire i_reset_sw, // Reset switch pulse
  input wire i_pc_break_hit, // PC break map hit
  input wire i_pc_break_on, // PC break set
  input wire i_ram_break_command, // RAM break set
  input wire [`EBC_RADDR_W-1:0] i_ram_addr_val, // RAM break address
  input wire [`EBC_RADDR_W-1:0] i_ram_addr_mask, // Address mask, 1 ignores
  input wire [`EBC_DATA_W-1:0] i_ram_data_val, // RAM break data
  input wire [`EBC_DATA_W-1:0] i_ram_data_mask, // Data mask
  input wire i_ram_wr_val, // RAM break R/W, 1 write
  input wire i_ram_wr_mask, // R/W mask
  input wire i_register_break_command, // Register break set
  input wire [`EBC_REG_W-1:0] i_reg_val, // Register break values
  input wire [`EBC_REG_W-1:0] i_reg_mask, // Register mask
  input wire i_compound_break_command, // Compound break set
  input wire i_cpu_cycle, // Target bus cycle valid
  input wire i_cpu_fetch, // Fetch cycle, first half
  input wire i_cpu_boundary, // Instruction end
  input wire i_cpu_stopped, // Target in halt/sleep
  input wire [`EBC_ADDR_W-1:0] i_cpu_pc, // Target PC
  input wire i_mem_access, // Data memory access
  input wire i_mem_write, // Access is write
  input wire [`EBC_RADDR_W-1:0] i_mem_addr, // Data memory address
  input wire [`EBC_DATA_W-1:0] i_mem_data, // Data memory data
  input wire [`EBC_REG_W-1:0] i_cpu_regs, // Target registers
  input wire [`EBC_HIST_W-1:0] i_hist_word, // History entry of the cycle
  input wire i_prog_load, // Program memory load request
  input wire [`EBC_HIST_AW-1:0] i_hist_raddr, // History read address
  output reg o_cpu_run, // Target run enable
  output reg o_emu_lamp, // Emulation lamp
  output reg o_halt_lamp, // Halt lamp
  output reg o_prog_we, // Program load granted
  output reg [`EBC_HIST_W-1:0] o_hist_rdata, // History read data
  output reg [`EBC_HIST_AW-1:0] o_hist_wptr, // Next history slot
  output reg o_hist_wrapped, // History full once
  output reg o_break_en, // Break enable mode
  output reg o_break_trace, // Break trace mode
  output reg o_sync_n, // Sync pin, low pulse
  output reg o_halt_n, // Halt pin, low pulse
  output reg [1:0] o_break_cause, // Last break cause
  output reg o_report_pulse, // Register report request
  output reg o_reset_emu, // Emulator reset pulse
  output reg [`EBC_ADDR_W-1:0] o_otf_pc, // On-the-fly PC
  output reg o_otf_halt // On-the-fly halt state
);
  localparam ST_SETUP = 4'b0001;
  localparam ST_RUN = 4'b0010;
  localparam ST_STEP = 4'b0100;
  localparam ST_PAUSE = 4'b1000;
  reg [3:0] state;
  reg [3:0] next_state;
  reg [3:0] pause_cnt;
  reg sync_en;
  reg pend_sw;
  reg pend_esc;
  reg pend_match;
  reg sync_pend;
  reg stopped_q;
  reg [1:0] next_cause;
  wire [`EBC_HIST_W-1:0] hist_q;
  wire running;
  wire pc_hit;
  wire ram_hit;
  wire reg_hit;
  wire match;
  wire stop_now;
  wire resume_now;
  function masked_eq;
    input [`EBC_REG_W-1:0] a;
    input [`EBC_REG_W-1:0] b;
    input [`EBC_REG_W-1:0] m;
    begin
      masked_eq = ((a ^ b) & ~m) == {`EBC_REG_W{1'b0}};
    end
  endfunction
  assign running = (state == ST_RUN) || (state == ST_STEP);
  assign pc_hit = i_pc_break_hit;
  assign ram_hit = i_mem_access &&
    masked_eq({20'h0, i_mem_addr}, {20'h0, i_ram_addr_val}, {20'h0, i_ram_addr_mask}) &&
    masked_eq({28'h0, i_mem_data}, {28'h0, i_ram_data_val}, {28'h0, i_ram_data_mask}) &&
    (i_ram_wr_mask || (i_mem_write == i_ram_wr_val));
  assign reg_hit = masked_eq(i_cpu_regs, i_reg_val, i_reg_mask);
  assign match = i_cpu_cycle && (i_compound_break_command ?
    ((!i_pc_break_on || pc_hit) && (!i_ram_break_command || ram_hit) &&
     (!i_register_break_command || reg_hit)) :
    ((i_pc_break_on && pc_hit) || (i_ram_break_command && ram_hit) ||
     (i_register_break_command && reg_hit)));
  assign stop_now = running && i_cpu_boundary &&
    (pend_sw || pend_esc || (pend_match && o_break_en) || state == ST_STEP);
  assign resume_now = (state == ST_PAUSE) && (pause_cnt == 4'h0);
  always @* begin
    if (pend_sw) begin
      next_cause = `EBC_CAUSE_SW;
    end else if (pend_esc) begin
      next_cause = `EBC_CAUSE_ESC;
    end else if (pend_match) begin
      next_cause = `EBC_CAUSE_MATCH;
    end else begin
      next_cause = `EBC_CAUSE_NONE;
    end
  end
  always @* begin
    next_state = state;
    case (state)
      ST_SETUP: begin
        if (i_run_cmd) begin
          next_state = ST_RUN;
        end else if (i_step_cmd) begin
          next_state = ST_STEP;
        end
      end
      ST_RUN: begin
        if (stop_now) begin
          next_state = (!pend_sw && !pend_esc && o_break_trace) ? ST_PAUSE : ST_SETUP;
        end
      end
      ST_STEP: begin
        if (stop_now) begin
          next_state = ST_SETUP;
        end
      end
      ST_PAUSE: begin
        if (pend_sw || pend_esc) begin
          next_state = ST_SETUP;
        end else if (resume_now) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_SETUP;
      end
    endcase
  end
  always @(posedge i_clk) begin
    if (i_sys_rst || i_reset_sw) begin
      state <= ST_SETUP;
      pause_cnt <= 4'h0;
      pend_sw <= 1'b0;
      pend_esc <= 1'b0;
      pend_match <= 1'b0;
      sync_pend <= 1'b0;
      stopped_q <= 1'b0;
      o_cpu_run <= 1'b0;
      o_emu_lamp <= 1'b0;
      o_halt_lamp <= 1'b1;
      o_prog_we <= 1'b0;
      o_hist_wptr <= {`EBC_HIST_AW{1'b0}};
      o_hist_wrapped <= 1'b0;
      o_sync_n <= 1'b1;
      o_halt_n <= 1'b1;
      o_break_cause <= `EBC_CAUSE_NONE;
      o_report_pulse <= 1'b0;
      o_reset_emu <= i_reset_sw;
      o_otf_pc <= {`EBC_ADDR_W{1'b0}};
      o_otf_halt <= 1'b0;
    end else begin
      state <= next_state;
      o_reset_emu <= 1'b0;
      o_cpu_run <= (next_state == ST_RUN) || (next_state == ST_STEP);
      o_emu_lamp <= next_state != ST_SETUP;
      o_halt_lamp <= next_state == ST_SETUP;
      o_prog_we <= i_prog_load && (state == ST_SETUP);
      // latch switch and escape, clear wins
      // Kept through a trace pause so a press there still halts
      pend_sw <= (i_break_sw || pend_sw) && state != ST_SETUP && next_state != ST_SETUP;
      pend_esc <= (i_host_escape_request || pend_esc) && state != ST_SETUP
        && next_state != ST_SETUP;
      pend_match <= running && ((match || pend_match) && !stop_now);
      if (state == ST_PAUSE) begin
        pause_cnt <= pause_cnt - 4'h1;
      end else begin
        pause_cnt <= `EBC_TRACE_PAUSE;
      end
      o_report_pulse <= (stop_now && (next_state != ST_SETUP || next_cause != `EBC_CAUSE_NONE
        || state == ST_STEP)) || (state == ST_PAUSE && next_state == ST_SETUP);
      if (stop_now || (state == ST_PAUSE && next_state == ST_SETUP)) begin
        o_break_cause <= next_cause;
      end
      if (running && i_cpu_cycle) begin
        o_hist_wptr <= o_hist_wptr + {{(`EBC_HIST_AW-1){1'b0}}, 1'b1};
        if (&o_hist_wptr) begin
          o_hist_wrapped <= 1'b1;
        end
      end
      if (running && match && !o_break_en && sync_en) begin
        sync_pend <= 1'b1;
      end else if (i_cpu_fetch) begin
        sync_pend <= 1'b0;
      end
      o_sync_n <= !(sync_pend && i_cpu_fetch);
      stopped_q <= i_cpu_stopped;
      o_halt_n <= !(i_cpu_stopped && !stopped_q);
      if (running) begin
        o_otf_pc <= i_cpu_pc;
        o_otf_halt <= i_cpu_stopped;
      end
    end
  end
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_break_en <= `EBC_RST_BREAK_EN;
      o_break_trace <= `EBC_RST_TRACE;
      sync_en <= 1'b0;
    end else begin
      if (i_trace_break_command || i_enable_break_command) begin
        o_break_en <= 1'b1;
      end else if (i_disable_break_command) begin
        o_break_en <= 1'b0;
      end
      if (i_trace_break_command) begin
        o_break_trace <= 1'b1;
      end else if (i_stop_break_command) begin
        o_break_trace <= 1'b0;
      end
      if (i_pulse_out_write) begin
        sync_en <= i_pulse_out_command;
      end
    end
  end
  always @(posedge i_clk) begin
    if (i_sys_rst || state != ST_SETUP) begin
      o_hist_rdata <= {`EBC_HIST_W{1'b0}};
    end else begin
      o_hist_rdata <= hist_q;
    end
  end
  ebc_hist_mem u_hist (
    .i_clk(i_clk),
    .i_we(running && i_cpu_cycle),
    .i_waddr(o_hist_wptr),
    .i_wdata(i_hist_word),
    .i_raddr(i_hist_raddr),
    .o_rdata(hist_q)
  );
endmodule // ebc_break_ctrl

/* File: sim/ebc_target_model.sv */
`timescale 1ns/1ps
module ebc_target_model (
  input wire logic i_clk, // System clock
  input wire logic i_run, // Run enable from block
  output logic o_cycle, // Bus cycle valid
  output logic o_fetch, // Fetch first half
  output logic o_boundary, // Instruction end
  output logic [11:0] o_pc // Program counter
);
  logic [1:0] cnt = 2'h0;
  logic run_q = 1'b0;
  initial o_pc = 12'h000;
  // four-cycle instructions, first fetch seen by the block
  always @(negedge i_clk) begin
    run_q <= i_run;
    cnt <= (i_run && run_q) ? cnt + 2'h1 : 2'h0;
    if (run_q && cnt == 2'h3) o_pc <= o_pc + 12'h001;
  end
  assign o_cycle = i_run;
  assign o_fetch = i_run && cnt == 2'h0;
  assign o_boundary = i_run && cnt == 2'h3;
endmodule // ebc_target_model

/* File: sim/ebc_break_ctrl_assertions.sv */
`timescale 1ns/1ps
module ebc_chk (
  input wire logic i_clk, i_sys_rst, i_run_cmd, i_reset_sw, i_cpu_boundary, i_cpu_fetch,
  input wire logic i_trace_break_command, i_prog_load, o_cpu_run, o_emu_lamp, o_halt_lamp,
  input wire logic o_break_en, o_break_trace, o_report_pulse, o_sync_n, o_prog_we,
  input wire logic [87:0] o_hist_rdata
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  run_lamps_a: assert property (o_cpu_run |-> o_emu_lamp && !o_halt_lamp) else $error("lamps");
  run_start_a: assert property (i_run_cmd && !o_cpu_run && o_halt_lamp && !i_reset_sw |=> o_cpu_run)
    else $error("no run");
  stop_edge_a: assert property ($fell(o_cpu_run) |-> $past(i_cpu_boundary) || $past(i_reset_sw))
    else $error("stop mid instruction");
  stop_report_a: assert property ($fell(o_cpu_run) && !$past(i_reset_sw) |-> o_report_pulse)
    else $error("no report");
  reset_sw_a: assert property (i_reset_sw |=> !o_cpu_run && !o_report_pulse) else $error("reset sw");
  trace_en_a: assert property (i_trace_break_command |=> o_break_trace && o_break_en) else $error("trace");
  load_setup_a: assert property (o_prog_we |-> $past(i_prog_load) && !$past(o_cpu_run)) else $error("load");
  hist_hide_a: assert property (o_cpu_run && $past(o_cpu_run) |-> o_hist_rdata == 88'h0) else $error("hist");
  sync_pulse_a: assert property (!o_sync_n |-> $past(i_cpu_fetch) ##1 o_sync_n) else $error("sync");
  c_sync: cover property (!o_sync_n);
  c_report: cover property (o_report_pulse);
  c_trace: cover property (o_break_trace && $fell(o_cpu_run));
endmodule // ebc_chk
bind ebc_break_ctrl ebc_chk u_chk (.*);

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic i_clk = 0, i_sys_rst = 1, i_run_cmd = 0, i_step_cmd = 0, i_enable_break_command = 0;
  logic i_disable_break_command = 0, i_trace_break_command = 0, i_stop_break_command = 0;
  logic i_pulse_out_command = 0, i_pulse_out_write = 0, i_host_escape_request = 0, i_break_sw = 0;
  logic i_reset_sw = 0, i_pc_break_hit = 0, i_pc_break_on = 1, i_ram_break_command = 0, i_ram_wr_val = 0;
  logic i_ram_wr_mask = 0, i_register_break_command = 0, i_compound_break_command = 0;
  logic i_cpu_stopped = 0, i_mem_access = 0, i_mem_write = 0, i_prog_load = 0;
  logic [11:0] i_ram_addr_val = 0, i_ram_addr_mask = 0, i_mem_addr = 0;
  logic [3:0] i_ram_data_val = 0, i_ram_data_mask = 0, i_mem_data = 0;
  logic [31:0] i_reg_val = 0, i_reg_mask = 0, i_cpu_regs = 0;
  logic [87:0] i_hist_word = 0, o_hist_rdata;
  logic [12:0] i_hist_raddr = 0, o_hist_wptr;
  logic [11:0] i_cpu_pc, o_otf_pc;
  logic [1:0] o_break_cause;
  logic i_cpu_cycle, i_cpu_fetch, i_cpu_boundary, o_cpu_run, o_emu_lamp, o_halt_lamp, o_prog_we;
  logic o_hist_wrapped, o_break_en, o_break_trace, o_sync_n, o_halt_n, o_report_pulse, o_reset_emu, o_otf_halt;
  int err_count = 0, checks_done = 0;
  ebc_break_ctrl dut (.*);
  ebc_target_model tgt (.i_clk(i_clk), .i_run(o_cpu_run), .o_cycle(i_cpu_cycle), .o_fetch(i_cpu_fetch),
    .o_boundary(i_cpu_boundary), .o_pc(i_cpu_pc));
  always #50 i_clk = ~i_clk;
  task finish_test;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [3:0] got, input logic [3:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    @(negedge i_clk);
    s = 0;
  endtask
  task wait_run(input logic v);
    int n;
    n = 0;
    while (o_cpu_run !== v && n < 60) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 60) begin
      err_count++;
      $display("MISMATCH %0t wait", $time);
      finish_test;
    end
  endtask
  task start_run;
    pulse(i_run_cmd);
    chk({o_cpu_run, o_emu_lamp, o_halt_lamp}, 4'h6, "run");
  endtask
  task t_reset_vals;
    chk({o_cpu_run, o_emu_lamp, o_halt_lamp, o_break_en}, 4'h3, "setup");
    chk({o_break_trace, o_sync_n, o_halt_n}, 4'h3, "idle pins");
    i_prog_load = 1;
    repeat (2) @(negedge i_clk);
    i_prog_load = 0;
    chk(o_prog_we, 1, "load");
  endtask
  task t_step;
    repeat (2) begin
      pulse(i_step_cmd);
      wait_run(0);
    end
    chk({o_report_pulse, o_halt_lamp, o_break_cause}, 4'hc, "step");
    chk(o_hist_wptr[3:0], 4'h8, "history count");
    chk(o_otf_pc[3:0], 4'h1, "on-the-fly pc");
    i_cpu_stopped = 1;
    @(negedge i_clk);
    chk(o_halt_n, 0, "halt pin");
    @(negedge i_clk);
    i_cpu_stopped = 0;
    chk(o_halt_n, 1, "halt pulse ends");
  endtask
  task t_halt(input int src, input logic [1:0] cause);
    start_run;
    i_break_sw = src[0];
    i_host_escape_request = src[1];
    @(negedge i_clk);
    {i_break_sw, i_host_escape_request} = 0;
    wait_run(0);
    chk({o_report_pulse, o_halt_lamp, o_break_cause}, {2'h3, cause}, "halt");
  endtask
  task t_match_stop;
    i_pc_break_hit = 1;
    start_run;
    wait_run(0);
    i_pc_break_hit = 0;
    chk({o_report_pulse, o_break_cause}, 4'h5, "match stop");
  endtask
  task t_reset_sw;
    start_run;
    pulse(i_reset_sw);
    chk({o_cpu_run, o_reset_emu, o_report_pulse}, 4'h2, "reset sw");
  endtask
  task t_disable_sync;
    int n;
    pulse(i_disable_break_command);
    i_pulse_out_command = 1;
    pulse(i_pulse_out_write);
    i_pc_break_hit = 1;
    start_run;
    n = 0;
    while (o_sync_n !== 0 && n < 30) begin
      @(negedge i_clk);
      n++;
    end
    chk({o_sync_n, o_cpu_run, o_break_en}, 4'h2, "sync");
    i_pc_break_hit = 0;
    t_halt(2, 2'h2);
  endtask
  task t_trace;
    pulse(i_trace_break_command);
    chk({o_break_en, o_break_trace}, 4'h3, "trace forces enable");
    i_pc_break_hit = 1;
    start_run;
    wait_run(0);
    chk(o_report_pulse, 1, "trace report");
    i_pc_break_hit = 0;
    wait_run(1);
    chk(o_cpu_run, 1, "trace resume");
    pulse(i_stop_break_command);
    t_halt(2, 2'h2);
  endtask
  initial begin
    repeat (4) @(negedge i_clk);
    i_sys_rst = 0;
    @(negedge i_clk);
    t_reset_vals;
    t_step;
    t_halt(1, 2'h3);
    t_halt(2, 2'h2);
    t_halt(3, 2'h3);
    t_match_stop;
    t_reset_sw;
    t_disable_sync;
    t_trace;
    finish_test;
  end
endmodule // tb_top
